// ==== rtl/etc_timer_top.sv ====
// Purpose: Count clock select and mode control of three 8-bit timers
// Assumes: CPU writes bytes or single bits at the documented addresses
// Notes:   Third timer counts only; it has no wave output
import etc_pkg::*;

// How it works
// RULE1 - Timer B select: pin falling/rising, fclk, /2,/16,/64,/256, aux H1 output.
// RULE2 - Timer C select: gated input edges, same dividers, 111 gives fclk/4096.
// RULE3 - Software writes zero to clock select bits 3 to 7.
// RULE4 - Software stops a timer before changing its clock select.
// RULE5 - Run bit low clears and holds counter; high lets it count.
// RULE6 - Mode bit 6: 0 clear-and-start on match, 1 free-running PWM.
// RULE7 - Preset bits: 00 no change, 01 clear flip-flop, 10 set it.
// RULE8 - Bit 1 enables toggle on match, or picks PWM active level.
// RULE9 - Output enable low forces timer output low.
// RULE10 - Preset bits of modes A and B are write-only, read zero.
// RULE11 - Preset bits act only outside PWM mode.
// RULE12 - Software programs mode bits, enable, preset, run in four writes.
// RULE13 - Software leaves other mode bits alone while running.
// RULE14 - In PWM, clearing run drives output to inactive level.
// RULE15 - Mode, preset, level and enable reach the output immediately.
// RULE16 - Pin level also depends on port direction and latch.
// RULE17 - Timer C mode register holds only run bit 7.
// RULE18 - Mode, preset, level and output exist only on timers A and B.
// RULE19 - Reset clears every mode control register.
// RULE20 - Registers accept single-bit and whole-byte writes.
// RULE21 - Counter rises per count clock; clears on reset, stop, match.
// RULE22 - Match raises request outside PWM; in PWM ends active phase.
// RULE23 - Pin and timer clock sources synchronised and edge detected first.
module etc_timer_top #(
  parameter int unsigned DIV_SLOW_A_LOG2 = LOG_DIV8K
) (
  // Clock, reset, freeze
  input  wire logic              CLK_SYS_I,
  input  wire logic              RST_N_I,
  input  wire logic              CE_I,
  // CPU register access
  input  wire etc_pkg::etc_addr_t REG_ADDR_I,
  input  wire etc_pkg::etc_byte_t REG_WDATA_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_BIT_WR_I,
  input  wire logic [2:0]        REG_BIT_SEL_I,
  input  wire logic              REG_BIT_VAL_I,
  input  wire logic              REG_RD_I,
  output etc_pkg::etc_byte_t     REG_RDATA_O,
  // Count sources
  input  wire logic              EVENT_INPUT_A_I,
  input  wire logic              EVENT_INPUT_B_I,
  input  wire logic              EVENT_INPUT_C_I,
  input  wire logic              AUX_H1_OUT_I,
  input  wire logic              AUX_H2_OUT_I,
  input  wire logic              GATED_INPUT_SELECT_I,
  // Compare values
  input  wire etc_pkg::etc_byte_t COMPARE_VALUE_A_I,
  input  wire etc_pkg::etc_byte_t COMPARE_VALUE_B_I,
  input  wire etc_pkg::etc_byte_t COMPARE_VALUE_C_I,
  // Count values and match requests
  output etc_pkg::etc_byte_t     COUNT_VALUE_A_O,
  output etc_pkg::etc_byte_t     COUNT_VALUE_B_O,
  output etc_pkg::etc_byte_t     COUNT_VALUE_C_O,
  output logic                   MATCH_INTERRUPT_A_O,
  output logic                   MATCH_INTERRUPT_B_O,
  output logic                   MATCH_INTERRUPT_C_O,
  // Shared port pins
  input  wire logic              PORT_DIR_A_I,
  input  wire logic              PORT_LATCH_A_I,
  input  wire logic              PORT_DIR_B_I,
  input  wire logic              PORT_LATCH_B_I,
  output logic                   WAVE_OUTPUT_PIN_A_O,
  output logic                   WAVE_OUTPUT_PIN_A_OE_N_O,
  output logic                   WAVE_OUTPUT_PIN_B_O,
  output logic                   WAVE_OUTPUT_PIN_B_OE_N_O
);
  import etc_pkg::*;
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [2:0]       ev_s1;
    logic [2:0]       ev_s2;
    logic [1:0]       aux_s1;
    logic [1:0]       aux_s2;
    logic [2:0]       ev_prev;
    logic             h1_prev;
    logic [PRE_W-1:0] pre;
    etc_byte_t        csel_a;
    etc_byte_t        csel_b;
    etc_byte_t        csel_c;
    etc_byte_t        mode_a;
    etc_byte_t        mode_b;
    etc_byte_t        mode_c;
    logic [1:0]       pset_hi;
    logic [1:0]       pset_lo;
    etc_byte_t        rdata;
    logic [1:0]       pin;
    logic [1:0]       pin_oe_n;
  } etc_top_st_t;
  etc_top_st_t s_ff;
  etc_top_st_t nxt_s;
  etc_byte_t   cur;
  etc_byte_t   wval;
  logic        wr;
  logic        gated_c;
  logic [2:0]  fall;
  logic [2:0]  rise;
  logic        h1_rise;
  etc_chan_if  a_if ();
  etc_chan_if  b_if ();
  etc_chan_if  c_if ();
  // ************************************************************
  // Helpers
  // ************************************************************
  // Prescaler tap: one pulse every 2**k enabled cycles
  function automatic logic ptick(input logic [PRE_W-1:0] p, input int unsigned k);
    logic [PRE_W-1:0] m;
    m = PRE_W'((1 << k) - 1);
    return (p & m) == m;
  endfunction
  // Merge a byte or single-bit write into the visible value
  function automatic etc_byte_t merge(input etc_byte_t old, input logic bitw,
                                      input logic [2:0] sel, input logic v,
                                      input etc_byte_t d);
    etc_byte_t r;
    r = old;
    if (bitw)
      r[sel] = v;
    else
      r = d;
    return r;
  endfunction
  // Count enable from a clock select code
  function automatic logic pick(input logic [2:0] sel, input logic f, input logic r,
                                input logic [PRE_W-1:0] p, input logic [2:0] mid,
                                input logic alt);
    logic t;
    case (etc_csel_t'(sel))
      CS_FALL:   t = f;
      CS_RISE:   t = r;
      CS_FULL:   t = 1'b1;
      CS_DIV2:   t = ptick(p, LOG_DIV2);
      CS_DIVM:   t = ptick(p, 32'(mid));
      CS_DIV64:  t = ptick(p, LOG_DIV64);
      CS_DIV256: t = ptick(p, LOG_DIV256);
      CS_ALT:    t = alt;
      default:   t = 1'b0;
    endcase
    return t;
  endfunction
  // ************************************************************
  // Edge detection on synchronised sources
  // ************************************************************
  // Gate is applied after the second stage so the first stays private
  always_comb
  begin
    gated_c = s_ff.ev_s2[2] & (GATED_INPUT_SELECT_I ? s_ff.aux_s2[1] : 1'b1);
    fall    = s_ff.ev_prev & ~{gated_c, s_ff.ev_s2[1:0]}; // RULE23
    rise    = ~s_ff.ev_prev & {gated_c, s_ff.ev_s2[1:0]}; // RULE23
    h1_rise = s_ff.aux_s2[0] & ~s_ff.h1_prev; // RULE23
  end
  // ************************************************************
  // Register read view and write decode
  // ************************************************************
  // Preset bits are never stored, so they read back zero
  always_comb
  begin
    case (REG_ADDR_I)
      ADDR_CSEL_A: cur = s_ff.csel_a;
      ADDR_CSEL_B: cur = s_ff.csel_b;
      ADDR_CSEL_C: cur = s_ff.csel_c;
      ADDR_MODE_A: cur = s_ff.mode_a; // RULE10
      ADDR_MODE_B: cur = s_ff.mode_b; // RULE10
      ADDR_MODE_C: cur = s_ff.mode_c;
      default:     cur = 8'h00;
    endcase
    wr   = REG_WR_I | REG_BIT_WR_I;
    wval = merge(cur, REG_BIT_WR_I, REG_BIT_SEL_I, REG_BIT_VAL_I, REG_WDATA_I); // RULE20
  end
  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    nxt_s = s_ff;
    // Two stages on every event and aux input level
    nxt_s.ev_s1  = {EVENT_INPUT_C_I, EVENT_INPUT_B_I, EVENT_INPUT_A_I}; // RULE23
    nxt_s.ev_s2  = s_ff.ev_s1;
    nxt_s.aux_s1 = {AUX_H2_OUT_I, AUX_H1_OUT_I}; // RULE23
    nxt_s.aux_s2 = s_ff.aux_s1;
    nxt_s.ev_prev = {gated_c, s_ff.ev_s2[1:0]};
    nxt_s.h1_prev = s_ff.aux_s2[0];
    // Free prescaler shared by all three timers
    nxt_s.pre = s_ff.pre + PRE_W'(1);
    nxt_s.pset_hi = 2'b00;
    nxt_s.pset_lo = 2'b00;
    if (wr)
    begin
      case (REG_ADDR_I)
        ADDR_CSEL_A: nxt_s.csel_a = wval & MASK_CSEL;
        ADDR_CSEL_B: nxt_s.csel_b = wval & MASK_CSEL;
        ADDR_CSEL_C: nxt_s.csel_c = wval & MASK_CSEL;
        ADDR_MODE_A:
        begin
          nxt_s.mode_a = wval & MASK_MODE_AB;
          nxt_s.pset_hi[0] = wval[BIT_PSET_HI] & ~wval[BIT_PSET_LO]; // RULE7
          nxt_s.pset_lo[0] = wval[BIT_PSET_LO] & ~wval[BIT_PSET_HI]; // RULE7
        end
        ADDR_MODE_B:
        begin
          nxt_s.mode_b = wval & MASK_MODE_AB;
          nxt_s.pset_hi[1] = wval[BIT_PSET_HI] & ~wval[BIT_PSET_LO]; // RULE7
          nxt_s.pset_lo[1] = wval[BIT_PSET_LO] & ~wval[BIT_PSET_HI]; // RULE7
        end
        ADDR_MODE_C: nxt_s.mode_c = wval & MASK_MODE_C; // RULE17
        default: ;
      endcase
    end
    if (REG_RD_I)
      nxt_s.rdata = cur;
    // Pin: timer output ORed with port latch, driven only in output mode
    nxt_s.pin      = {PORT_LATCH_B_I | b_if.wave, PORT_LATCH_A_I | a_if.wave}; // RULE16
    nxt_s.pin_oe_n = {PORT_DIR_B_I, PORT_DIR_A_I}; // RULE16
  end
  // Freeze everything while the clock enable is low
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      s_ff <= '0; // RULE19
    else if (CE_I)
      s_ff <= nxt_s;
  end
  // ************************************************************
  // Channel control
  // ************************************************************
  assign a_if.tick    = pick(s_ff.csel_a[2:0], fall[0], rise[0], s_ff.pre, 3'(LOG_DIV4),
                             ptick(s_ff.pre, DIV_SLOW_A_LOG2));
  assign a_if.run     = s_ff.mode_a[BIT_RUN]; // RULE5
  assign a_if.pwm     = s_ff.mode_a[BIT_PWM]; // RULE6
  assign a_if.inv     = s_ff.mode_a[BIT_INV]; // RULE8
  assign a_if.oe      = s_ff.mode_a[BIT_OE]; // RULE9
  assign a_if.pset_hi = s_ff.pset_hi[0];
  assign a_if.pset_lo = s_ff.pset_lo[0];
  assign a_if.cmp     = COMPARE_VALUE_A_I;
  assign b_if.tick    = pick(s_ff.csel_b[2:0], fall[1], rise[1], s_ff.pre, 3'(LOG_DIV16),
                             h1_rise); // RULE1
  assign b_if.run     = s_ff.mode_b[BIT_RUN]; // RULE5
  assign b_if.pwm     = s_ff.mode_b[BIT_PWM]; // RULE6
  assign b_if.inv     = s_ff.mode_b[BIT_INV]; // RULE8
  assign b_if.oe      = s_ff.mode_b[BIT_OE]; // RULE9
  assign b_if.pset_hi = s_ff.pset_hi[1];
  assign b_if.pset_lo = s_ff.pset_lo[1];
  assign b_if.cmp     = COMPARE_VALUE_B_I;
  assign c_if.tick    = pick(s_ff.csel_c[2:0], fall[2], rise[2], s_ff.pre, 3'(LOG_DIV16),
                             ptick(s_ff.pre, LOG_DIV4K)); // RULE2
  assign c_if.run     = s_ff.mode_c[BIT_RUN]; // RULE5 RULE17
  // Counting only on the third timer
  assign c_if.pwm     = 1'b0; // RULE18
  assign c_if.inv     = 1'b0; // RULE18
  assign c_if.oe      = 1'b0; // RULE18
  assign c_if.pset_hi = 1'b0;
  assign c_if.pset_lo = 1'b0;
  assign c_if.cmp     = COMPARE_VALUE_C_I;
  // ************************************************************
  // Channels
  // ************************************************************
  etc_chan #(.HAS_OUT(1'b1)) u_chan_a (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .ch      (a_if.chan)
  );
  etc_chan #(.HAS_OUT(1'b1)) u_chan_b (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .ch      (b_if.chan)
  );
  etc_chan #(.HAS_OUT(1'b0)) u_chan_c (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .ch      (c_if.chan)
  );
  // ************************************************************
  // Outputs
  // ************************************************************
  assign REG_RDATA_O              = s_ff.rdata;
  assign COUNT_VALUE_A_O          = a_if.cnt;
  assign COUNT_VALUE_B_O          = b_if.cnt;
  assign COUNT_VALUE_C_O          = c_if.cnt;
  assign MATCH_INTERRUPT_A_O      = a_if.match;
  assign MATCH_INTERRUPT_B_O      = b_if.match;
  assign MATCH_INTERRUPT_C_O      = c_if.match;
  assign WAVE_OUTPUT_PIN_A_O      = s_ff.pin[0];
  assign WAVE_OUTPUT_PIN_B_O      = s_ff.pin[1];
  assign WAVE_OUTPUT_PIN_A_OE_N_O = s_ff.pin_oe_n[0];
  assign WAVE_OUTPUT_PIN_B_OE_N_O = s_ff.pin_oe_n[1];
  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  property p_rd_preset_zero;
    CE_I && REG_RD_I && (REG_ADDR_I == ADDR_MODE_A || REG_ADDR_I == ADDR_MODE_B)
      |=> REG_RDATA_O[3:2] == 2'b00;
  endproperty
  a_rd_preset_zero: assert property (p_rd_preset_zero) else $error("preset bits read nonzero"); // RULE10
  sequence s_wr_then_rd;
    CE_I && REG_WR_I && !REG_BIT_WR_I && REG_ADDR_I == ADDR_MODE_A
      ##1 CE_I && !REG_WR_I && !REG_BIT_WR_I
      ##1 CE_I && !REG_WR_I && !REG_BIT_WR_I && REG_RD_I && REG_ADDR_I == ADDR_MODE_A;
  endsequence
  // Write, one idle cycle, then read back the kept bits
  property p_byte_rw;
    s_wr_then_rd |=> REG_RDATA_O == ($past(REG_WDATA_I, 3) & MASK_MODE_AB);
  endproperty
  a_byte_rw: assert property (p_byte_rw) else $error("byte write not read back"); // RULE20
  property p_mode_c;
    CE_I && REG_WR_I && !REG_BIT_WR_I && REG_ADDR_I == ADDR_MODE_C
      |=> c_if.run == $past(REG_WDATA_I[7]) && s_ff.mode_c[6:0] == 7'h00;
  endproperty
  a_mode_c: assert property (p_mode_c) else $error("third mode register wrong"); // RULE17
  property p_preset_pulse;
    CE_I && REG_WR_I && !REG_BIT_WR_I && REG_ADDR_I == ADDR_MODE_B && REG_WDATA_I[3:2] == 2'b10
      |=> b_if.pset_hi && !b_if.pset_lo ##1 !b_if.pset_hi;
  endproperty
  a_preset_pulse: assert property (p_preset_pulse) else $error("preset pulse wrong"); // RULE7
  property p_b_full;
    s_ff.csel_b[2:0] == CS_FULL |-> b_if.tick;
  endproperty
  a_b_full: assert property (p_b_full) else $error("full rate tick missing"); // RULE1
  property p_c_slow;
    s_ff.csel_c[2:0] == CS_ALT && c_if.tick |-> s_ff.pre[11:0] == 12'hFFF;
  endproperty
  a_c_slow: assert property (p_c_slow) else $error("slow tick off phase"); // RULE2
endmodule

// ==== rtl/etc_pkg.sv ====
// Purpose: Shared constants and types of the 8-bit timer clock/mode block
// Assumes: One peripheral clock; registers sit on the internal CPU bus
// Notes:   Offsets are the byte addresses seen by the CPU
package etc_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  typedef logic [15:0] etc_addr_t;
  typedef logic [7:0]  etc_byte_t;
  localparam etc_addr_t ADDR_CSEL_A = 16'hFF6A;
  localparam etc_addr_t ADDR_MODE_A = 16'hFF6B;
  localparam etc_addr_t ADDR_CSEL_B = 16'hFF8C;
  localparam etc_addr_t ADDR_MODE_B = 16'hFF43;
  localparam etc_addr_t ADDR_CSEL_C = 16'hFF5B;
  localparam etc_addr_t ADDR_MODE_C = 16'hFF5C;
  localparam etc_byte_t REG_RESET   = 8'h00;
  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int unsigned BIT_RUN      = 7;
  localparam int unsigned BIT_PWM      = 6;
  localparam int unsigned BIT_PSET_HI  = 3;
  localparam int unsigned BIT_PSET_LO  = 2;
  localparam int unsigned BIT_INV      = 1;
  localparam int unsigned BIT_OE       = 0;
  localparam etc_byte_t   MASK_CSEL    = 8'h07;
  localparam etc_byte_t   MASK_MODE_AB = 8'hC3;
  localparam etc_byte_t   MASK_MODE_C  = 8'h80;
  // ************************************************************
  // Count clock selection
  // ************************************************************
  typedef enum logic [2:0] {
    CS_FALL  = 3'b000,
    CS_RISE  = 3'b001,
    CS_FULL  = 3'b010,
    CS_DIV2  = 3'b011,
    CS_DIVM  = 3'b100,
    CS_DIV64 = 3'b101,
    CS_DIV256 = 3'b110,
    CS_ALT   = 3'b111
  } etc_csel_t;
  localparam int unsigned PRE_W      = 13;
  localparam int unsigned LOG_DIV2   = 1;
  localparam int unsigned LOG_DIV4   = 2;
  localparam int unsigned LOG_DIV16  = 4;
  localparam int unsigned LOG_DIV64  = 6;
  localparam int unsigned LOG_DIV256 = 8;
  localparam int unsigned LOG_DIV4K  = 12;
  localparam int unsigned LOG_DIV8K  = 13;
endpackage

// ==== rtl/etc_chan_if.sv ====
// Purpose: Control and status bundle between register block and a channel
// Assumes: Same clock on both sides
// Notes:   tick is a one-cycle count enable
interface etc_chan_if;
  logic       tick;
  logic       run;
  logic       pwm;
  logic       inv;
  logic       oe;
  logic       pset_hi;
  logic       pset_lo;
  logic [7:0] cmp;
  logic [7:0] cnt;
  logic       match;
  logic       wave;
  // Register block side
  modport ctrl (output tick, run, pwm, inv, oe, pset_hi, pset_lo, cmp,
                input cnt, match, wave);
  // Counter channel side
  modport chan (input tick, run, pwm, inv, oe, pset_hi, pset_lo, cmp,
                output cnt, match, wave);
endinterface

// ==== rtl/etc_chan.sv ====
// Purpose: One 8-bit counter with compare, output flip-flop and PWM
// Assumes: tick already synchronised and edge detected
// Notes:   HAS_OUT=0 gives a counting-only channel
module etc_chan #(
  parameter bit HAS_OUT = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  etc_chan_if.chan ch
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       pwm_act;
    logic       out_ff;
    logic       match;
  } etc_chan_st_t;
  etc_chan_st_t s_ff;
  etc_chan_st_t nxt_s;
  // ************************************************************
  // Counting and output flip-flop
  // ************************************************************
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.match = 1'b0;
    if (!ch.run)
    begin
      nxt_s.cnt = 8'h00; // RULE5
      nxt_s.pwm_act = 1'b0; // RULE14
    end
    else if (ch.tick)
    begin
      if (!ch.pwm && s_ff.cnt == ch.cmp)
      begin
        nxt_s.cnt = 8'h00; // RULE21
        nxt_s.match = 1'b1; // RULE22
        if (ch.inv)
          nxt_s.out_ff = ~s_ff.out_ff; // RULE8
      end
      else
      begin
        nxt_s.cnt = s_ff.cnt + 8'h01; // RULE21
        // Match wins over wrap so CR=FF keeps the output at its inactive level
        if (ch.pwm && s_ff.cnt == ch.cmp)
          nxt_s.pwm_act = 1'b0; // RULE22
        else if (ch.pwm && s_ff.cnt == 8'hFF)
          nxt_s.pwm_act = 1'b1;
      end
    end
    // Preset beats toggle; ignored in PWM mode
    if (!ch.pwm && ch.pset_hi)
      nxt_s.out_ff = 1'b1; // RULE7 RULE11
    else if (!ch.pwm && ch.pset_lo)
      nxt_s.out_ff = 1'b0; // RULE7 RULE11
    if (!HAS_OUT)
      nxt_s.out_ff = 1'b0;
  end
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_ff <= '0; // RULE19
    else if (ce_i)
      s_ff <= nxt_s;
  end
  // Output follows mode bits at once, running or not
  assign ch.wave  = HAS_OUT && ch.oe &&
                    (ch.pwm ? (s_ff.pwm_act ^ ch.inv) : s_ff.out_ff); // RULE9 RULE15 RULE8
  assign ch.cnt   = s_ff.cnt;
  assign ch.match = s_ff.match;
  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_hit;
    ce_i && ch.run && ch.tick && !ch.pwm && s_ff.cnt == ch.cmp;
  endsequence
  property p_match_clear;
    s_hit |=> (s_ff.cnt == 8'h00) && ch.match;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("no clear on match"); // RULE21
  property p_stop_clear;
    ce_i && !ch.run |=> s_ff.cnt == 8'h00 && !ch.match;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stopped counter not zero"); // RULE5
  property p_pwm_no_irq;
    ce_i && ch.pwm |=> !ch.match;
  endproperty
  a_pwm_no_irq: assert property (p_pwm_no_irq) else $error("match request in PWM"); // RULE22
  property p_oe_low;
    !ch.oe |-> !ch.wave;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("output not low when disabled"); // RULE9
  property p_pwm_stop;
    ce_i && ch.pwm && !ch.run ##1 ch.pwm && ch.oe |-> ch.wave == (HAS_OUT && ch.inv);
  endproperty
  a_pwm_stop: assert property (p_pwm_stop) else $error("PWM not inactive when stopped"); // RULE14
  property p_preset;
    ce_i && !ch.pwm && ch.pset_hi |=> s_ff.out_ff == HAS_OUT;
  endproperty
  a_preset: assert property (p_preset) else $error("preset high ignored"); // RULE11
endmodule

// ==== test/etc_tb.sv ====
// Purpose: Self-checking bench for the timer clock and mode block
// Assumes: CPU strobes driven on falling edges, one cycle each
// Notes:   Expected read values are queued and checked by a separate watcher
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import etc_pkg::*;
  logic      clk, rst_n, wr, bwr, rd, bval, ev_a, ev_b, ev_c, h1, h2, gsel;
  logic      dir_a, lat_a, dir_b, lat_b, m_a, m_b, m_c, pin_a, oen_a, pin_b, oen_b, ce;
  etc_addr_t addr;
  etc_byte_t wdata, rdata, cmp_a, cmp_b, cmp_c, cnt_a, cnt_b, cnt_c;
  logic [2:0] bsel;
  etc_byte_t exp_q[$];
  int        miscompares, total_checks, cyc, seed, n, k, c, e;
  logic      p1, r;
  int        sa[5] = '{2, 3, 4, 5, 7};
  int        da[5] = '{1, 2, 4, 64, 8};
  int        lb[5] = '{0, 1, 4, 6, 8};
  etc_timer_top #(.DIV_SLOW_A_LOG2(3)) dut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_BIT_WR_I(bwr), .REG_BIT_SEL_I(bsel), .REG_BIT_VAL_I(bval), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .EVENT_INPUT_A_I(ev_a), .EVENT_INPUT_B_I(ev_b), .EVENT_INPUT_C_I(ev_c),
    .AUX_H1_OUT_I(h1), .AUX_H2_OUT_I(h2), .GATED_INPUT_SELECT_I(gsel), .COMPARE_VALUE_A_I(cmp_a),
    .COMPARE_VALUE_B_I(cmp_b), .COMPARE_VALUE_C_I(cmp_c), .COUNT_VALUE_A_O(cnt_a),
    .COUNT_VALUE_B_O(cnt_b), .COUNT_VALUE_C_O(cnt_c), .MATCH_INTERRUPT_A_O(m_a),
    .MATCH_INTERRUPT_B_O(m_b), .MATCH_INTERRUPT_C_O(m_c), .PORT_DIR_A_I(dir_a),
    .PORT_LATCH_A_I(lat_a), .PORT_DIR_B_I(dir_b), .PORT_LATCH_B_I(lat_b),
    .WAVE_OUTPUT_PIN_A_O(pin_a), .WAVE_OUTPUT_PIN_A_OE_N_O(oen_a),
    .WAVE_OUTPUT_PIN_B_O(pin_b), .WAVE_OUTPUT_PIN_B_OE_N_O(oen_b));
  // ************************************************************
  // Bus tasks
  // ************************************************************
  task automatic wr_b(input etc_addr_t a, input etc_byte_t d);
    @(negedge clk); addr = a; wdata = d; wr = 1'b1;
    @(negedge clk); wr = 1'b0;
  endtask
  task automatic wr_bit(input etc_addr_t a, input int b, input logic v);
    @(negedge clk); addr = a; bsel = b[2:0]; bval = v; bwr = 1'b1;
    @(negedge clk); bwr = 1'b0;
  endtask
  // Expected value noted before the strobe rises
  task automatic rd_b(input etc_addr_t a, input etc_byte_t d);
    @(negedge clk); addr = a; exp_q.push_back(d); rd = 1'b1;
    @(negedge clk); rd = 1'b0;
  endtask
  task automatic pulse(ref logic s, input int num);
    repeat (num)
    begin
      @(negedge clk); s = 1'b1; repeat (2) @(negedge clk);
      s = 1'b0; repeat (2) @(negedge clk);
    end
    repeat (6) @(negedge clk);
  endtask
  // Bounded wait between two match pulses of timer A
  task automatic gap(output int g);
    g = 0;
    while (!m_a && g < 600) begin @(negedge clk); g++; end
    g = 1; @(negedge clk);
    while (!m_a && g < 600) begin @(negedge clk); g++; end
  endtask
  task automatic pin_is(input logic v);
    repeat (3) @(negedge clk);
    `CHK(pin_a, v)
  endtask
  task automatic close_out();
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ************************************************************
  // Clock, watcher, watchdog
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Read data settles after the taking edge; sample late in the high phase
  always @(posedge clk)
  begin
    r = rd; #20;
    if (r && exp_q.size() > 0) `CHK(rdata, exp_q.pop_front())
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000) begin miscompares++; close_out(); end
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    seed = 96; {wr, bwr, rd, bval, ev_a, ev_b, ev_c, h1, h2, gsel, lat_a, lat_b, dir_b} = '0;
    dir_a = 1'b0; ce = 1'b1; addr = '0; wdata = '0; bsel = '0; cmp_a = 8'h02; cmp_b = 8'hFF; cmp_c = 8'hFF;
    rst_n = 1'b0; repeat (2) @(negedge clk); rst_n = 1'b1;
    foreach (sa[i]) rd_b(i < 3 ? ADDR_CSEL_A + 16'(i) * 16'h0 : ADDR_MODE_C, REG_RESET);
    rd_b(ADDR_MODE_A, 8'h00); rd_b(ADDR_MODE_B, 8'h00); rd_b(16'hFF00, 8'h00);
    foreach (sa[i]) if (i < 3)
    begin
      e = i; addr = (e == 0) ? ADDR_CSEL_A : (e == 1) ? ADDR_CSEL_B : ADDR_CSEL_C;
      wr_b(addr, 8'h07); rd_b(addr, 8'h07); wr_b(addr, 8'h00);
    end
    wr_b(ADDR_MODE_C, 8'h80); rd_b(ADDR_MODE_C, 8'h80);
    wr_bit(ADDR_MODE_C, 7, 1'b0); rd_b(ADDR_MODE_C, 8'h00);
    wr_b(ADDR_MODE_A, 8'h42); wr_b(ADDR_MODE_A, 8'h43); wr_b(ADDR_MODE_A, 8'h47);
    rd_b(ADDR_MODE_A, 8'h43);
    wr_bit(ADDR_MODE_A, 6, 1'b0); rd_b(ADDR_MODE_A, 8'h03);
    wr_b(ADDR_MODE_A, 8'h0B); pin_is(1'b1);
    wr_b(ADDR_MODE_A, 8'h07); pin_is(1'b0);
    wr_b(ADDR_MODE_A, 8'h0B); wr_b(ADDR_MODE_A, 8'h02); pin_is(1'b0);
    wr_b(ADDR_MODE_A, 8'h03); pin_is(1'b1);
    wr_b(ADDR_MODE_A, 8'h43); pin_is(1'b1);
    wr_b(ADDR_MODE_A, 8'h47); pin_is(1'b1);
    wr_b(ADDR_MODE_A, 8'h03); pin_is(1'b1);
    wr_b(ADDR_MODE_A, 8'h41); pin_is(1'b0);
    lat_a = 1'b1; pin_is(1'b1);
    `CHK(oen_a, 1'b0)
    lat_a = 1'b0; wr_b(ADDR_CSEL_A, 8'h02); wr_b(ADDR_MODE_A, 8'hC1); n = 0;
    repeat (40) begin @(negedge clk); n += m_a; end
    `CHK(n, 0)
    `CHK(cnt_a > 8'h02, 1'b1)
    wr_b(ADDR_MODE_A, 8'h41); pin_is(1'b0);
    `CHK(cnt_a, 8'h00)
    wr_b(ADDR_MODE_A, 8'h43); wr_b(ADDR_MODE_A, 8'h03); wr_b(ADDR_MODE_A, 8'h07);
    foreach (sa[i])
    begin
      wr_b(ADDR_MODE_A, 8'h03); wr_b(ADDR_CSEL_A, 8'(sa[i])); wr_b(ADDR_MODE_A, 8'h83);
      gap(n); p1 = pin_a; `CHK(n, 3 * da[i])
      gap(n); `CHK(pin_a, ~p1)
    end
    foreach (sa[i])
    begin
      wr_b(ADDR_MODE_B, 8'h00); wr_b(ADDR_CSEL_B, 8'(i + 2)); wr_b(ADDR_MODE_B, 8'h80);
      repeat (200) @(negedge clk); c = cnt_b; e = 200 >> lb[i];
      `CHK(c + 3 >= e && c <= e + 1, 1'b1)
    end
    for (int s = 0; s < 8; s += (s == 1) ? 6 : 1)
    begin
      wr_b(ADDR_MODE_B, 8'h00); wr_b(ADDR_CSEL_B, 8'(s)); wr_b(ADDR_MODE_B, 8'h80);
      k = 2 + ($unsigned($random(seed)) % 6);
      if (s == 7) pulse(h1, k); else pulse(ev_b, k);
      `CHK(cnt_b, 8'(k))
    end
    wr_b(ADDR_MODE_B, 8'h00); repeat (2) @(negedge clk);
    `CHK(cnt_b, 8'h00)
    wr_b(ADDR_MODE_B, 8'h01); wr_b(ADDR_MODE_B, 8'h09); dir_b = 1'b1; repeat (3) @(negedge clk);
    `CHK(pin_b, 1'b1)
    `CHK(oen_b, 1'b1)
    cmp_b = 8'h03; wr_b(ADDR_CSEL_B, 8'h02); wr_b(ADDR_MODE_B, 8'h81); n = 0;
    repeat (40) begin @(negedge clk); n += m_b; end
    `CHK(n, 10)
    // Clock enable low must freeze the running counter
    ce = 1'b0; c = cnt_b; repeat (5) @(negedge clk);
    `CHK(cnt_b, 8'(c))
    ce = 1'b1;
    gsel = 1'b1; wr_b(ADDR_CSEL_C, 8'h01); wr_b(ADDR_MODE_C, 8'h80); pulse(ev_c, 3);
    `CHK(cnt_c, 8'h00)
    h2 = 1'b1; repeat (4) @(negedge clk); pulse(ev_c, 3);
    `CHK(cnt_c, 8'h03)
    cmp_c = 8'h03; ev_c = 1'b1; n = 0;
    repeat (6) begin @(negedge clk); n += m_c; end
    `CHK(n, 1)
    `CHK(cnt_c, 8'h00)
    close_out();
  end
endmodule
